// [ssr_ctrl_model.sv]
// remote controller model issuing commands and serial polls
`timescale 1ns/1ps
`default_nettype none
module ssr_ctrl_model (
   input  wire logic             sys_clk_i,
   output var ssr_pkg::ssr_cmd_t cmd_o,
   output var logic              poll_o
);
   initial cmd_o = '0;
   initial poll_o = 1'b0;
   task send(input logic [3:0] code, input logic sel, input logic [15:0] data);
      @(posedge sys_clk_i);
      #1 cmd_o = {1'b1, ssr_pkg::ssr_cmd_code_t'(code), sel, data};
      @(posedge sys_clk_i);
      #1 cmd_o = {1'b0, cmd_o.code, ~sel, ~data};
   endtask
   task poll;
      @(posedge sys_clk_i);
      #1 poll_o = 1'b1;
      @(posedge sys_clk_i);
      #1 poll_o = 1'b0;
   endtask
endmodule // ssr_ctrl_model
`default_nettype wire

// [ssr_params.svh]
// constants of the status reporting block
`ifndef SSR_PARAMS_SVH
`define SSR_PARAMS_SVH
// ********************************
// part layout
// ********************************
`define SSR_PART_W      16
`define SSR_PART_MASK   16'h7fff
`define SSR_RISE_RST    16'h7fff
`define SSR_FALL_RST    16'h0000
`define SSR_MASK_RST    16'h0000
`define SSR_EVT_RST     16'h0000
`define SSR_REQ_RST     8'h00
`define SSR_ESE_RST     8'h00
// ********************************
// status byte bits
// ********************************
`define SSR_STB_ERR     2
`define SSR_STB_QUES    3
`define SSR_STB_MAV     4
`define SSR_STB_ESB     5
`define SSR_STB_MSS     6
`define SSR_STB_OPER    7
`define SSR_REQ_IGNORE  8'hbf
// ********************************
// register selection
// ********************************
`define SSR_SEL_OPER    1'b0
`define SSR_SEL_QUES    1'b1
`endif

// [ssr_pkg.sv]
// types of the status reporting block
`default_nettype none
package ssr_pkg;
   typedef enum logic [3:0] {
      SSR_CMD_RD_COND  = 4'h0,
      SSR_CMD_RD_RISE  = 4'h1,
      SSR_CMD_WR_RISE  = 4'h2,
      SSR_CMD_RD_FALL  = 4'h3,
      SSR_CMD_WR_FALL  = 4'h4,
      SSR_CMD_RD_EVT   = 4'h5,
      SSR_CMD_RD_MASK  = 4'h6,
      SSR_CMD_WR_MASK  = 4'h7,
      SSR_CMD_RD_STB   = 4'h8,
      SSR_CMD_RD_REQ   = 4'h9,
      SSR_CMD_WR_REQ   = 4'ha,
      SSR_CMD_RD_ESE   = 4'hb,
      SSR_CMD_WR_ESE   = 4'hc
   } ssr_cmd_code_t;

   typedef struct packed {
      logic          valid;
      ssr_cmd_code_t code;
      logic          sel;
      logic [15:0]   data;
   } ssr_cmd_t;

   typedef struct packed {
      logic        valid;
      logic [15:0] data;
   } ssr_rsp_t;

   typedef struct packed {
      logic [1:0][15:0] cond;
      logic [1:0][15:0] rise;
      logic [1:0][15:0] fall;
      logic [1:0][15:0] evt;
      logic [1:0][15:0] mask;
      logic [7:0]       ese;
      logic [7:0]       req;
      logic [7:0]       stb;
      ssr_rsp_t         rsp;
      ssr_rsp_t         poll;
      logic             srq;
      logic [1:0]       sum;
   } ssr_state_t;
endpackage
`default_nettype wire

// [ssr_status_asserts.sv]
// checker on the status reporting ports
`timescale 1ns/1ps
`default_nettype none
module ssr_status_asserts (
   input wire logic              sys_clk_i,
   input wire logic              rst_i,
   input wire ssr_pkg::ssr_cmd_t cmd_i,
   input wire logic              poll_i,
   input wire logic [15:0]       oper_cond_i,
   input wire logic              err_queue_busy_i,
   input wire logic              msg_avail_i,
   input wire ssr_pkg::ssr_rsp_t rsp_o,
   input wire ssr_pkg::ssr_rsp_t poll_o,
   input wire logic [7:0]        stb_o,
   input wire logic              srq_o,
   input wire logic              oper_sum_o,
   input wire logic              ques_sum_o
);
   // ******
   // properties
   // ******
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wr;
      cmd_i.valid && cmd_i.code inside {4'h2, 4'h4, 4'h7, 4'ha, 4'hc};
   endsequence
   sequence s_rd;
      cmd_i.valid && !(cmd_i.code inside {4'h2, 4'h4, 4'h7, 4'ha, 4'hc});
   endsequence
   a_read_answer: assert property (s_rd |=> rsp_o.valid) else $error("read not answered");
   a_write_quiet: assert property (s_wr |=> !rsp_o.valid) else $error("write answered");
   a_bit15_zero: assert property (rsp_o.valid |-> !rsp_o.data[15]) else $error("bit 15 set");
   a_cond_live: assert property (s_rd ##0 (cmd_i.code == 4'h0 && !cmd_i.sel) |=>
      rsp_o.data == ($past(oper_cond_i) & 16'h7fff)) else $error("condition not live");
   a_poll_byte: assert property (poll_i |=> poll_o.valid && poll_o.data == {8'h00, stb_o})
      else $error("poll answer wrong");
   a_stb_unused: assert property (stb_o[1:0] == 2'b00) else $error("unused bits set");
   a_level_bits: assert property (!$past(rst_i) |-> stb_o[2] == $past(err_queue_busy_i)
      && stb_o[4] == $past(msg_avail_i)) else $error("queue bits wrong");
   a_sum_bits: assert property (stb_o[3] == ques_sum_o && stb_o[7] == oper_sum_o)
      else $error("summary bits differ");
   a_mss_cause: assert property (stb_o[6] |-> |{stb_o[7], stb_o[5:0]})
      else $error("main summary without cause");
   a_srq_mss: assert property (srq_o |-> stb_o[6]) else $error("request without summary");
endmodule // ssr_status_asserts
bind ssr_status_top ssr_status_asserts chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_i(cmd_i),
   .poll_i(poll_i), .oper_cond_i(oper_cond_i), .err_queue_busy_i(err_queue_busy_i),
   .msg_avail_i(msg_avail_i), .rsp_o(rsp_o), .poll_o(poll_o), .stb_o(stb_o), .srq_o(srq_o),
   .oper_sum_o(oper_sum_o), .ques_sum_o(ques_sum_o));
`default_nettype wire

// [ssr_status_top.sv]
// status reporting: two five-part registers, status byte, request mask
`timescale 1ns/1ps
`default_nettype none
`include "ssr_params.svh"
module ssr_status_top #(
   parameter int PART_W = 16
) (
   input  wire logic            sys_clk_i,
   input  wire logic            rst_i,
   input  wire ssr_pkg::ssr_cmd_t cmd_i,
   input  wire logic            poll_i,
   input  wire logic [15:0]     oper_cond_i,
   input  wire logic [15:0]     ques_cond_i,
   input  wire logic [7:0]      esr_events_i,
   input  wire logic            err_queue_busy_i,
   input  wire logic            msg_avail_i,
   output var  ssr_pkg::ssr_rsp_t rsp_o,
   output var  ssr_pkg::ssr_rsp_t poll_o,
   output logic [7:0]           stb_o,
   output logic                 srq_o,
   output logic                 oper_sum_o,
   output logic                 ques_sum_o
);
   // ********************************
   // elaboration check
   // ********************************
   generate
      if (PART_W != `SSR_PART_W) begin : g_bad_w
         $error("part width must be 16");
      end
   endgenerate

   // ********************************
   // state
   // ********************************
   ssr_pkg::ssr_state_t st_ff;
   ssr_pkg::ssr_state_t nxt_st;

   logic [1:0][15:0] live;
   logic [1:0][15:0] rise_edge;
   logic [1:0][15:0] fall_edge;
   logic [1:0]       sum_now;
   logic [7:0]       stb_now;
   logic [7:0]       req_eff;
   logic             esb;
   logic             is_oper;

   always_comb begin
      live[0] = oper_cond_i & `SSR_PART_MASK;
      live[1] = ques_cond_i & `SSR_PART_MASK;
      is_oper = (cmd_i.sel == `SSR_SEL_OPER);
      nxt_st  = st_ff;
      nxt_st.rsp.valid  = 1'b0;
      nxt_st.rsp.data   = 16'h0000;
      nxt_st.poll.valid = 1'b0;
      for (int i = 0; i < 2; i++) begin
         // same bit index in every part
         nxt_st.cond[i] = live[i];
         rise_edge[i] = live[i] & ~st_ff.cond[i] & st_ff.rise[i];
         fall_edge[i] = ~live[i] & st_ff.cond[i] & st_ff.fall[i];
         nxt_st.evt[i] = st_ff.evt[i];
         if (cmd_i.valid && cmd_i.code == ssr_pkg::SSR_CMD_RD_EVT &&
             cmd_i.sel == i[0]) begin
            nxt_st.evt[i] = `SSR_EVT_RST;
         end
         // new transitions set after the clear
         nxt_st.evt[i] = (nxt_st.evt[i] | rise_edge[i] | fall_edge[i])
                         & `SSR_PART_MASK;
         sum_now[i] = |(nxt_st.evt[i] & st_ff.mask[i]);
      end
      nxt_st.sum = sum_now;
      esb = |(esr_events_i & st_ff.ese);
      stb_now = 8'h00;
      stb_now[`SSR_STB_ERR]  = err_queue_busy_i;
      stb_now[`SSR_STB_QUES] = sum_now[1];
      stb_now[`SSR_STB_MAV]  = msg_avail_i;
      stb_now[`SSR_STB_ESB]  = esb;
      stb_now[`SSR_STB_OPER] = sum_now[0];
      req_eff = st_ff.req & `SSR_REQ_IGNORE;
      stb_now[`SSR_STB_MSS] = |(stb_now & req_eff);
      nxt_st.stb = stb_now;
      nxt_st.srq = |(stb_now & ~st_ff.stb & req_eff);
      if (poll_i) begin
         nxt_st.poll.valid = 1'b1;
         nxt_st.poll.data  = {8'h00, stb_now};
      end
      if (cmd_i.valid) begin
         nxt_st.rsp.valid = 1'b1;
         unique case (cmd_i.code)
            ssr_pkg::SSR_CMD_RD_COND:
               nxt_st.rsp.data = is_oper ? live[0] : live[1];
            ssr_pkg::SSR_CMD_RD_RISE:
               nxt_st.rsp.data = st_ff.rise[cmd_i.sel];
            ssr_pkg::SSR_CMD_WR_RISE: begin
               nxt_st.rise[cmd_i.sel] = cmd_i.data & `SSR_PART_MASK;
               nxt_st.rsp.valid = 1'b0;
            end
            ssr_pkg::SSR_CMD_RD_FALL:
               nxt_st.rsp.data = st_ff.fall[cmd_i.sel];
            ssr_pkg::SSR_CMD_WR_FALL: begin
               nxt_st.fall[cmd_i.sel] = cmd_i.data & `SSR_PART_MASK;
               nxt_st.rsp.valid = 1'b0;
            end
            ssr_pkg::SSR_CMD_RD_EVT:
               nxt_st.rsp.data = st_ff.evt[cmd_i.sel];
            ssr_pkg::SSR_CMD_RD_MASK:
               nxt_st.rsp.data = st_ff.mask[cmd_i.sel];
            ssr_pkg::SSR_CMD_WR_MASK: begin
               nxt_st.mask[cmd_i.sel] = cmd_i.data & `SSR_PART_MASK;
               nxt_st.rsp.valid = 1'b0;
            end
            ssr_pkg::SSR_CMD_RD_STB:
               nxt_st.rsp.data = {8'h00, stb_now};
            ssr_pkg::SSR_CMD_RD_REQ:
               nxt_st.rsp.data = {8'h00, st_ff.req};
            ssr_pkg::SSR_CMD_WR_REQ: begin
               nxt_st.req = cmd_i.data[7:0];
               nxt_st.rsp.valid = 1'b0;
            end
            ssr_pkg::SSR_CMD_RD_ESE:
               nxt_st.rsp.data = {8'h00, st_ff.ese};
            ssr_pkg::SSR_CMD_WR_ESE: begin
               nxt_st.ese = cmd_i.data[7:0];
               nxt_st.rsp.valid = 1'b0;
            end
            default: begin
               nxt_st.rsp.valid = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_ff      <= '0;
         st_ff.rise <= {2{`SSR_RISE_RST}};
         st_ff.fall <= {2{`SSR_FALL_RST}};
         st_ff.mask <= {2{`SSR_MASK_RST}};
         st_ff.req  <= `SSR_REQ_RST;
         st_ff.ese  <= `SSR_ESE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ********************************
   // outputs
   // ********************************
   assign rsp_o      = st_ff.rsp;
   assign poll_o     = st_ff.poll;
   assign stb_o      = st_ff.stb;
   assign srq_o      = st_ff.srq;
   assign oper_sum_o = st_ff.sum[0];
   assign ques_sum_o = st_ff.sum[1];
endmodule // ssr_status_top
`default_nettype wire

// [ssr_status_top_bench.sv]
// self-checking bench of the status reporting block
`timescale 1ns/1ps
`default_nettype none
module ssr_status_top_bench;
   logic              clk, rst, err, msg, pl, srq, osum, qsum;
   logic [15:0]       oc, qc, v;
   logic [7:0]        esr, stb;
   logic [15:0]       rq[$], pq[$];
   ssr_pkg::ssr_cmd_t cmd;
   ssr_pkg::ssr_rsp_t rsp, pol;
   int                n_errors = 0, n_tests = 0, seed = 62, i, k;
   logic [3:0]        wc[3] = '{4'h2, 4'h4, 4'h7}, rc[3] = '{4'h1, 4'h3, 4'h6};
   ssr_status_top uut (.sys_clk_i(clk), .rst_i(rst), .cmd_i(cmd), .poll_i(pl), .oper_cond_i(oc),
      .ques_cond_i(qc), .esr_events_i(esr), .err_queue_busy_i(err), .msg_avail_i(msg),
      .rsp_o(rsp), .poll_o(pol), .stb_o(stb), .srq_o(srq), .oper_sum_o(osum), .ques_sum_o(qsum));
   ssr_ctrl_model ctl (.sys_clk_i(clk), .cmd_o(cmd), .poll_o(pl));
   // ******
   // checking
   // ******
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task rd(input logic [3:0] code, input logic sel, input logic [15:0] exp);
      rq.push_back(exp);
      ctl.send(code, sel, 16'h0000);
   endtask
   task stop_test;
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(negedge clk) begin
      if (rsp.valid === 1'b1) cmp("rsp", rq.pop_front(), rsp.data);
      if (pol.valid === 1'b1) cmp("poll", pq.pop_front(), pol.data);
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      stop_test();
   end
   // ******
   // scenarios
   // ******
   initial begin
      {rst, err, msg, oc, qc, esr} = {3'b100, 40'h0};
      repeat (4) @(posedge clk);
      #1 rst = 1'b0;
      for (k = 0; k < 2; k++) begin
         rd(4'h1, k[0], 16'h7fff);
         rd(4'h3, k[0], 16'h0000);
         rd(4'h6, k[0], 16'h0000);
         rd(4'h5, k[0], 16'h0000);
      end
      for (i = 0; i < 6; i++) begin
         v = $random(seed);
         ctl.send(wc[i % 3], (i > 2), v);
         rd(rc[i % 3], (i > 2), v & 16'h7fff);
         rd(rc[i % 3], (i > 2), v & 16'h7fff);
      end
      v = $random(seed) & 16'h00bf;
      ctl.send(4'ha, 1'b0, v);
      rd(4'h9, 1'b0, v);
      ctl.send(4'h2, 1'b1, 16'h0001);
      ctl.send(4'h4, 1'b1, 16'h0002);
      ctl.send(4'h7, 1'b1, 16'h0001);
      @(posedge clk);
      #1 qc = 16'h0003;
      @(posedge clk);
      #1 qc = 16'h0000;
      repeat (2) @(posedge clk);
      #1 cmp("ques_sum", 16'h0001, {15'h0, qsum});
      rd(4'h5, 1'b1, 16'h0003);
      rd(4'h5, 1'b1, 16'h0000);
      cmp("ques_sum", 16'h0000, {15'h0, qsum});
      fork
         rd(4'h5, 1'b1, 16'h0000);
         begin @(posedge clk); #1 qc = 16'h0001; end
      join
      rd(4'h5, 1'b1, 16'h0001);
      ctl.send(4'ha, 1'b0, 16'h0010);
      ctl.send(4'hc, 1'b0, 16'h0001);
      rd(4'hb, 1'b0, 16'h0001);
      {err, msg, esr} = 10'h301;
      for (i = 0; i < 4 && srq !== 1'b1; i++) @(negedge clk);
      cmp("srq", 16'h0001, {15'h0, srq});
      cmp("stb", 16'h0074, {8'h00, stb});
      pq.push_back(16'h0074);
      ctl.poll();
      rd(4'h8, 1'b0, 16'h0074);
      v = $random(seed);
      oc = v;
      rd(4'h0, 1'b0, v & 16'h7fff);
      rd(4'h0, 1'b0, v & 16'h7fff);
      repeat (4) @(posedge clk);
      stop_test();
   end
endmodule // ssr_status_top_bench
`default_nettype wire
